/* lvp_regs.svh */
// Timing counts, limits and widths for the external serial-link clock generator
`ifndef LVP_REGS_SVH
`define LVP_REGS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define LVP_SYS_CLK_MHZ      250
`define LVP_LOCK_TIME_NS     2000
`define LVP_LOCK_CYCLES      ((`LVP_LOCK_TIME_NS * `LVP_SYS_CLK_MHZ + 999) / 1000)

// ****************************************
// Serialization factor limits
// ****************************************
`define LVP_FACTOR_W         4
`define LVP_FACTOR_DEFAULT   4'h4
`define LVP_FACTOR_MIN       4'h3
`define LVP_FACTOR_MAX       4'ha

// ****************************************
// Data path
// ****************************************
`define LVP_DATA_W           10
`define LVP_FIFO_DEPTH       4
`define LVP_HALF_W           5

`endif

/* lvp_pkg.sv */
// Types shared by the clock generator, its checker, the serializer model and the bench
`include "lvp_regs.svh"

package lvp_pkg;

  // ****************************************
  // Roles a generated output can play
  // ****************************************
  typedef enum logic [1:0] {
    LVP_ROLE_SERIAL,
    LVP_ROLE_LOAD,
    LVP_ROLE_PARALLEL,
    LVP_ROLE_PHASE
  } lvp_role_t;

  // ****************************************
  // Configuration request from the user
  // ****************************************
  typedef struct packed {
    logic [`LVP_FACTOR_W-1:0] ser_factor;
    logic                     dpa_mode;
  } lvp_cfg_t;

  // ****************************************
  // Clock and reset pins driven toward the serializer
  // ****************************************
  typedef struct packed {
    logic pll_serial_rate_out;
    logic pll_word_load_out;
    logic pll_parallel_out;
    logic pll_phase_align_out;
    logic pll_reset_out;
  } lvp_pins_t;

endpackage

/* lvp_fifo.sv */
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module lvp_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] wr_nxt;
  logic [AW-1:0] rd_r;
  logic [AW-1:0] rd_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  // Index step with wrap at the depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] idx);
    step = (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
  endfunction

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointers and fill level
  always_comb begin
    wr_nxt  = push ? step(wr_r) : wr_r;
    rd_nxt  = pop ? step(rd_r) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointer and level registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage, written on accepted push
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

endmodule
`default_nettype wire

/* lvp_clkgen.sv */
// External clock generator for a serializer link in external-PLL mode
`timescale 1ns/1ns
`default_nettype none
`include "lvp_regs.svh"

module lvp_clkgen
  import lvp_pkg::*;
#(
  parameter int        DATA_W     = `LVP_DATA_W,
  parameter int        FIFO_DEPTH = `LVP_FIFO_DEPTH,
  parameter lvp_role_t ROLE_OUT0  = LVP_ROLE_SERIAL,
  parameter lvp_role_t ROLE_OUT1  = LVP_ROLE_LOAD,
  parameter lvp_role_t ROLE_OUT2  = LVP_ROLE_PARALLEL,
  parameter lvp_role_t ROLE_OUT3  = LVP_ROLE_PHASE
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire lvp_cfg_t          cfg_in,
  input  wire logic              cfg_apply,
  output lvp_cfg_t               cfg_active,
  output logic                   cfg_reject,
  output logic                   locked,
  input  wire logic [DATA_W-1:0] word_in,
  input  wire logic              word_valid,
  output logic                   word_ready,
  output lvp_pins_t              pins,
  output logic [DATA_W-1:0]      tx_word,
  output logic                   tx_word_valid
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [1:0] {
    LVP_ST_RESET,
    LVP_ST_LOCKING,
    LVP_ST_RUN
  } lvp_state_t;

  localparam int LOCK_W = $clog2(`LVP_LOCK_CYCLES + 1);

  lvp_state_t               state_r;
  lvp_state_t               state_nxt;
  lvp_cfg_t                 cfg_r;
  lvp_cfg_t                 cfg_nxt;
  logic [LOCK_W-1:0]        lock_cnt_r;
  logic [LOCK_W-1:0]        lock_cnt_nxt;
  logic [`LVP_HALF_W-1:0]   half_r;
  logic [`LVP_HALF_W-1:0]   half_nxt;
  logic                     locked_r;
  logic                     locked_nxt;
  logic                     reject_r;
  logic                     reject_nxt;
  lvp_pins_t                pins_r;
  lvp_pins_t                pins_nxt;
  logic [DATA_W-1:0]        tx_word_r;
  logic [DATA_W-1:0]        tx_word_nxt;
  logic                     tx_valid_r;
  logic                     tx_valid_nxt;
  logic                     cfg_ok;
  logic                     word_edge;
  logic [DATA_W-1:0]        fifo_data;
  logic                     fifo_valid;
  logic                     fifo_pop;
  logic [3:0]               role_lvl;

  // ****************************************
  // Waveform of one role at a half-bit slot
  // ****************************************
  // One sys_clk cycle is half a serial bit; a word spans 2*factor slots.
  // Slot 0 starts a bit, so clock and data stay edge aligned at the pins.
  function automatic logic role_level(
    input lvp_role_t              role,
    input logic [`LVP_HALF_W-1:0] h,
    input lvp_cfg_t               c
  );
    logic [`LVP_HALF_W-1:0] f;
    logic [`LVP_HALF_W-1:0] span;
    f    = `LVP_HALF_W'(c.ser_factor);
    span = {c.ser_factor, 1'b0};
    case (role)
      // Low first half-bit, high second: -180 deg, 50% duty
      LVP_ROLE_SERIAL:   role_level = h[0];
      // One bit period wide, placed at bit factor-2 of the word
      LVP_ROLE_LOAD:     role_level = (h[`LVP_HALF_W-1:1] == (f - 2'h2));
      // High for factor slots, starting half a bit before the word
      LVP_ROLE_PARALLEL: role_level = (h == span - 1'b1) || (h < f - 1'b1);
      // Same timing as serial, only in phase-align mode
      LVP_ROLE_PHASE:    role_level = c.dpa_mode && h[0];
      default:           role_level = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Lock and reconfiguration control
  // ****************************************
  assign cfg_ok = (cfg_in.ser_factor >= `LVP_FACTOR_MIN)
               && (cfg_in.ser_factor <= `LVP_FACTOR_MAX);

  // State, active settings and lock count
  always_comb begin
    state_nxt    = state_r;
    cfg_nxt      = cfg_r;
    lock_cnt_nxt = lock_cnt_r;
    reject_nxt   = 1'b0;
    locked_nxt   = 1'b0;
    case (state_r)
      LVP_ST_RESET: begin
        lock_cnt_nxt = '0;
        state_nxt    = LVP_ST_LOCKING;
      end
      LVP_ST_LOCKING: begin
        // Lock time assumes a clean, non-modulated reference
        if (lock_cnt_r == LOCK_W'(`LVP_LOCK_CYCLES - 1)) begin
          state_nxt  = LVP_ST_RUN;
          locked_nxt = 1'b1;
        end else begin
          lock_cnt_nxt = lock_cnt_r + 1'b1;
        end
      end
      LVP_ST_RUN: begin
        locked_nxt = 1'b1;
        // New rate or mode: drop lock, relock on new settings
        if (cfg_apply && cfg_ok) begin
          cfg_nxt      = cfg_in;
          lock_cnt_nxt = '0;
          locked_nxt   = 1'b0;
          state_nxt    = LVP_ST_LOCKING;
        end
      end
      default: begin
        state_nxt = LVP_ST_RESET;
      end
    endcase
    // Out-of-range factors are refused and flagged
    if (cfg_apply && !cfg_ok) begin
      reject_nxt = 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r    <= LVP_ST_RESET;
      cfg_r      <= '{ser_factor: `LVP_FACTOR_DEFAULT, dpa_mode: 1'b0};
      lock_cnt_r <= '0;
      locked_r   <= 1'b0;
      reject_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cfg_r      <= cfg_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      locked_r   <= locked_nxt;
      reject_r   <= reject_nxt;
    end
  end

  // ****************************************
  // Half-bit slot counter and clock pins
  // ****************************************
  // Slot counter holds at the last slot while unlocked
  always_comb begin
    if (!locked_nxt) begin
      half_nxt = {cfg_nxt.ser_factor, 1'b0} - 1'b1;
    end else if (half_r == {cfg_r.ser_factor, 1'b0} - 1'b1) begin
      half_nxt = '0;
    end else begin
      half_nxt = half_r + 1'b1;
    end
  end

  // Each clock pin draws its waveform from its assigned role
  always_comb begin
    role_lvl[0] = role_level(ROLE_OUT0, half_nxt, cfg_nxt);
    role_lvl[1] = role_level(ROLE_OUT1, half_nxt, cfg_nxt);
    role_lvl[2] = role_level(ROLE_OUT2, half_nxt, cfg_nxt);
    role_lvl[3] = role_level(ROLE_OUT3, half_nxt, cfg_nxt);
    // Clocks are silent while the generator is not locked
    pins_nxt.pll_serial_rate_out = locked_nxt && role_lvl[0];
    pins_nxt.pll_word_load_out   = locked_nxt && role_lvl[1];
    pins_nxt.pll_parallel_out    = locked_nxt && role_lvl[2];
    pins_nxt.pll_phase_align_out = locked_nxt && role_lvl[3];
    // Receiver reset pin carries the inverted lock, in every mode
    pins_nxt.pll_reset_out       = !locked_nxt;
  end

  // Pin registers; no reset pin exists toward the transmitter
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      half_r <= '0;
      pins_r <= '{pll_reset_out: 1'b1, default: 1'b0};
    end else begin
      half_r <= half_nxt;
      pins_r <= pins_nxt;
    end
  end

  // ****************************************
  // Parallel word path
  // ****************************************
  // New word appears with the parallel clock rise, one per word period
  assign word_edge = locked_nxt && (half_nxt == {cfg_nxt.ser_factor, 1'b0} - 1'b1)
                  && locked_r;
  assign fifo_pop  = word_edge;

  lvp_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_data   (word_in),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Word held stable across the load enable that captures it
  always_comb begin
    tx_word_nxt  = tx_word_r;
    tx_valid_nxt = tx_valid_r && locked_nxt;
    if (word_edge) begin
      tx_word_nxt  = fifo_valid ? fifo_data : '0;
      tx_valid_nxt = fifo_valid;
    end
  end

  // Word registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_word_r  <= '0;
      tx_valid_r <= 1'b0;
    end else begin
      tx_word_r  <= tx_word_nxt;
      tx_valid_r <= tx_valid_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pins          = pins_r;
  assign cfg_active    = cfg_r;
  assign cfg_reject    = reject_r;
  assign locked        = locked_r;
  assign tx_word       = tx_word_r;
  assign tx_word_valid = tx_valid_r;

endmodule
`default_nettype wire

/* lvp_clkgen_assertions.sv */
// Assertion checker for the serial-link clock generator
`timescale 1ns/1ns
`default_nettype none

module lvp_clkgen_chk
  import lvp_pkg::*;
#(
  parameter int DATA_W = 10
) (
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire lvp_cfg_t          cfg_in,
  input wire logic              cfg_apply,
  input wire lvp_cfg_t          cfg_active,
  input wire logic              cfg_reject,
  input wire logic              locked,
  input wire logic [DATA_W-1:0] word_in,
  input wire logic              word_valid,
  input wire logic              word_ready,
  input wire lvp_pins_t         pins,
  input wire logic [DATA_W-1:0] tx_word,
  input wire logic              tx_word_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Pin, word and refusal relations
  // ****************************************
  property p_rst_lock;
    pins.pll_reset_out != locked;
  endproperty
  property p_ser;
    locked && $past(locked) |-> pins.pll_serial_rate_out != $past(pins.pll_serial_rate_out);
  endproperty
  property p_quiet;
    !locked |-> !(pins.pll_serial_rate_out | pins.pll_word_load_out
      | pins.pll_parallel_out | pins.pll_phase_align_out);
  endproperty
  property p_phase;
    pins.pll_phase_align_out == (pins.pll_serial_rate_out & cfg_active.dpa_mode);
  endproperty
  property p_ldw;
    $rose(pins.pll_word_load_out) && !cfg_apply |=>
      pins.pll_word_load_out ##1 !pins.pll_word_load_out;
  endproperty
  property p_ldph;
    $rose(pins.pll_word_load_out) |-> !pins.pll_serial_rate_out && !pins.pll_parallel_out;
  endproperty
  property p_par;
    $rose(pins.pll_parallel_out) && $past(locked) |-> pins.pll_serial_rate_out;
  endproperty
  property p_word;
    locked && $past(locked) && !$rose(pins.pll_parallel_out) |->
      $stable(tx_word) && $stable(tx_word_valid);
  endproperty
  property p_rej;
    cfg_apply && (cfg_in.ser_factor < 4'h3 || cfg_in.ser_factor > 4'ha) |=>
      cfg_reject && $stable(cfg_active);
  endproperty

  a_rst_lock: assert property (p_rst_lock) else $error("reset pin not inverse of lock");
  a_ser: assert property (p_ser) else $error("serial clock missed a toggle");
  a_quiet: assert property (p_quiet) else $error("clock active while unlocked");
  a_phase: assert property (p_phase) else $error("phase-align clock wrong");
  a_ldw: assert property (p_ldw) else $error("load pulse width wrong");
  a_ldph: assert property (p_ldph) else $error("load pulse phase wrong");
  a_par: assert property (p_par) else $error("parallel clock phase wrong");
  a_word: assert property (p_word) else $error("word changed off parallel edge");
  a_rej: assert property (p_rej) else $error("bad factor not refused");

  c_lock: cover property ($rose(locked));
  c_rej: cover property (cfg_reject);
  c_full: cover property (!word_ready);
  c_dpa: cover property (pins.pll_phase_align_out);
endmodule

bind lvp_clkgen lvp_clkgen_chk #(.DATA_W(DATA_W)) chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .cfg_in(cfg_in), .cfg_apply(cfg_apply), .cfg_active(cfg_active), .cfg_reject(cfg_reject),
  .locked(locked), .word_in(word_in), .word_valid(word_valid), .word_ready(word_ready),
  .pins(pins), .tx_word(tx_word), .tx_word_valid(tx_word_valid));

`default_nettype wire

/* lvp_ser_model.sv */
// Behavioural serializer that takes its serial and load clocks from the generator
`timescale 1ns/1ns
`default_nettype none

module lvp_ser_model
  import lvp_pkg::*;
#(
  parameter int DATA_W = 10
) (
  input  wire logic              sys_clk,
  input  wire lvp_pins_t         pins,
  input  wire logic [DATA_W-1:0] tx_word,
  input  wire logic              tx_word_valid,
  output logic                   got_stb,
  output logic [DATA_W-1:0]      got_word,
  output int                     bits
);
  logic ld_q;
  logic sr_q;
  int   bit_cnt;
  // Receiver reset pin always present, transmitter has none
  wire logic rx_rst = pins.pll_reset_out;

  // Word transfer on load pulse, serial clock only counts bits
  always @(posedge sys_clk) begin
    ld_q    <= pins.pll_word_load_out;
    sr_q    <= pins.pll_serial_rate_out;
    got_stb <= 1'b0;
    if (rx_rst) begin
      bit_cnt <= 0;
    end else if (pins.pll_word_load_out && !ld_q) begin
      got_stb  <= tx_word_valid;
      got_word <= tx_word;
      bits     <= bit_cnt;
      bit_cnt  <= 0;
    end else if (pins.pll_serial_rate_out && !sr_q) begin
      bit_cnt <= bit_cnt + 1;
    end
  end
endmodule

`default_nettype wire

/* lvp_clkgen_tb.sv */
// Self-checking bench for the serial-link clock generator
`timescale 1ns/1ns
`default_nettype none
`include "lvp_regs.svh"

module lvp_clkgen_tb
  import lvp_pkg::*;
;
  logic       sys_clk;
  logic       sys_rst;
  lvp_cfg_t   cfg_in;
  logic       cfg_apply;
  lvp_cfg_t   cfg_active;
  logic       cfg_reject;
  logic       locked;
  logic [9:0] word_in;
  logic       word_valid;
  logic       word_ready;
  lvp_pins_t  pins;
  logic [9:0] tx_word;
  logic       tx_word_valid;
  logic       got_stb;
  logic [9:0] got_word;
  int         bits;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         cur_f;
  int         n;
  int         bad[3] = '{2, 11, 0};
  logic [9:0] expq[$];

  // Clock source
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Default role map: each pin carries its own clock role
  lvp_clkgen dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_in(cfg_in), .cfg_apply(cfg_apply),
    .cfg_active(cfg_active), .cfg_reject(cfg_reject), .locked(locked), .word_in(word_in),
    .word_valid(word_valid), .word_ready(word_ready), .pins(pins), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid));
  lvp_ser_model dev (.sys_clk(sys_clk), .pins(pins), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .got_stb(got_stb), .got_word(got_word), .bits(bits));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    cur_f = 4;
    check("rst_pins", pins, 5'h01);
    check("rst_cfg", cfg_active, {4'h4, 1'b0});
    check("rst_rdy", word_ready, 1);
    check("rst_valid", tx_word_valid, 0);
  endtask

  task automatic wait_lock(output int k);
    k = 0;
    while (locked !== 1'b1) begin
      if (k == 1000) begin
        error_cnt++;
        summarize();
      end
      @(posedge sys_clk);
      #1;
      k++;
    end
  endtask

  task automatic apply(input int f, input logic d);
    @(posedge sys_clk);
    cfg_in <= '{ser_factor: f[3:0], dpa_mode: d};
    cfg_apply <= 1'b1;
    @(posedge sys_clk);
    cfg_apply <= 1'b0;
    #1;
  endtask

  // Two word periods hold exact counts of each clock's high cycles
  task automatic measure(input int f, input int d);
    int ld, par, ph, sr;
    ld = 0;
    par = 0;
    ph = 0;
    sr = 0;
    repeat (4 * f) begin
      @(posedge sys_clk);
      #1;
      ld += pins.pll_word_load_out;
      par += pins.pll_parallel_out;
      ph += pins.pll_phase_align_out;
      sr += pins.pll_serial_rate_out;
    end
    check("load_hi", ld, 4);
    check("par_hi", par, 2 * f);
    check("phase_hi", ph, d ? 2 * f : 0);
    check("ser_hi", sr, 2 * f);
  endtask

  // Eight random words back to back, refused ones dropped, then drain
  task automatic stream();
    logic [9:0] w;
    bit ok, full;
    full = 0;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      w = 10'($urandom);
      word_in <= w;
      word_valid <= 1'b1;
      #1;
      ok = word_ready;
      full |= !ok;
      @(posedge sys_clk);
      if (ok) expq.push_back(w);
    end
    word_valid <= 1'b0;
    n = 0;
    while (expq.size() != 0) begin
      if (n == 400) begin
        error_cnt++;
        summarize();
      end
      @(posedge sys_clk);
      n++;
    end
    check("full_seen", full, 1);
  endtask

  // Device side: every delivered word against the bench queue
  always @(negedge sys_clk) begin
    if (got_stb === 1'b1) begin
      check("word", got_word, expq.size() ? expq.pop_front() : 10'bx);
      check("bits", bits, cur_f);
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    cfg_in = '0;
    cfg_apply = 1'b0;
    word_in = '0;
    word_valid = 1'b0;
    void'($urandom(47108));
    do_reset();
    wait_lock(n);
    $display("test reset done");
    for (int f = 3; f <= 10; f++) begin
      for (int d = 0; d < 2; d++) begin
        apply(f, d[0]);
        check("unlock", locked, 0);
        check("rst_pin", pins.pll_reset_out, 1);
        check("cfg", cfg_active, {f[3:0], d[0]});
        cur_f = f;
        wait_lock(n);
        check("lock_time", n, `LVP_LOCK_CYCLES);
        measure(f, d);
        stream();
        $display("test factor %0d mode %0d done", f, d);
      end
    end
    foreach (bad[i]) begin
      apply(bad[i], 1'b0);
      check("reject", cfg_reject, 1);
      check("kept", cfg_active, {4'ha, 1'b1});
      check("still_locked", locked, 1);
    end
    $display("test refusal done");
    do_reset();
    wait_lock(n);
    measure(4, 0);
    $display("test second reset done");
    summarize();
  end
endmodule

`default_nettype wire
